// *** core/nvsc_host.sv ***
// Host controller driving an asynchronous nonvolatile SRAM through its pins
//
// Contract
// - Host holds address stable throughout the whole write.
// - Host keeps output drive high throughout every write.
// - Save follows six select-controlled reads ending at 0x0F0F.
// - Restore follows same five reads then a read at 0x0F0E.
// - Host steps sequences with reads only, never writes.
// - Host keeps strobe or select high as power-up restore ends.
// - Host holds write strobe high across all six sequence reads.
`timescale 1ns/1ps
`include "nvsc_defines.svh"

module nvsc_host #(
    parameter int SAVE_CYC    = `NVSC_SAVE_CYC,
    parameter int RESTORE_CYC = `NVSC_RESTORE_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire nvsc_pkg::nvsc_req_t req_i,
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    output logic [7:0]             rdata_o,
    output logic                   done_o,
    output logic [12:0]            addr_lines_o,
    output logic [7:0]             data_lines_o,
    output logic                   data_lines_oe_o,
    input  wire logic [7:0]        data_lines_i,
    output logic                   part_on_n_o,
    output logic                   write_strobe_n_o,
    output logic                   output_drive_n_o
);
    localparam int ACC_CYC = `NVSC_ACCESS_CYC;
    localparam int CNT_W   = $clog2(SAVE_CYC + 1) + 1;

    nvsc_pkg::nvsc_state_t state;
    nvsc_pkg::nvsc_req_t   cur;
    logic [CNT_W-1:0]      cnt;
    logic [2:0]            step;
    logic                  seq_mode;
    logic [7:0]            data_s1;
    logic [7:0]            data_s2;
    logic [12:0]           step_addr;

    // Sequence address table, last step depends on save or restore
    always_comb begin
        case (step)
            3'h0:    step_addr = `NVSC_SEQ0;
            3'h1:    step_addr = `NVSC_SEQ1;
            3'h2:    step_addr = `NVSC_SEQ2;
            3'h3:    step_addr = `NVSC_SEQ3;
            3'h4:    step_addr = `NVSC_SEQ4;
            default: step_addr = (cur.op == nvsc_pkg::NVSC_OP_SAVE) ?
                                 `NVSC_SEQ_SAVE : `NVSC_SEQ_RESTORE;
        endcase
    end

    // Two-flop synchroniser on the returning data lines
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
        end else begin
            data_s1 <= data_lines_i;
            data_s2 <= data_s1;
        end
    end

    // Cycle sequencer for single accesses and six-read sequences
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state            <= nvsc_pkg::NVSC_IDLE;
            cur              <= '0;
            cnt              <= '0;
            step             <= 3'h0;
            seq_mode         <= 1'b0;
            req_ready_o      <= 1'b0;
            rdata_o          <= 8'h00;
            done_o           <= 1'b0;
            addr_lines_o     <= 13'h0000;
            data_lines_o     <= 8'h00;
            data_lines_oe_o  <= 1'b0;
            part_on_n_o      <= 1'b1;
            write_strobe_n_o <= 1'b1;
            output_drive_n_o <= 1'b1;
        end else begin
            done_o      <= 1'b0;
            req_ready_o <= 1'b0;
            case (state)
                nvsc_pkg::NVSC_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        cur         <= req_i;
                        seq_mode    <= req_i.op[1];
                        step        <= 3'h0;
                        state       <= nvsc_pkg::NVSC_SETUP;
                    end
                end
                nvsc_pkg::NVSC_SETUP: begin
                    // Address settles while select is high
                    addr_lines_o <= seq_mode ? step_addr : cur.addr;
                    data_lines_o <= cur.wdata;
                    data_lines_oe_o <= (!seq_mode && cur.op == nvsc_pkg::NVSC_OP_WRITE);
                    cnt   <= CNT_W'(ACC_CYC);
                    state <= nvsc_pkg::NVSC_PULSE;
                end
                nvsc_pkg::NVSC_PULSE: begin
                    part_on_n_o <= 1'b0;
                    if (!seq_mode && cur.op == nvsc_pkg::NVSC_OP_WRITE) begin
                        write_strobe_n_o <= 1'b0;
                        output_drive_n_o <= 1'b1;
                    end else begin
                        write_strobe_n_o <= 1'b1;
                        output_drive_n_o <= 1'b0;
                    end
                    if (!part_on_n_o) begin
                        cnt <= cnt - CNT_W'(1);
                        if (cnt == CNT_W'(1)) begin
                            state <= nvsc_pkg::NVSC_HOLD;
                        end
                    end
                end
                nvsc_pkg::NVSC_HOLD: begin
                    // Select, strobe and drive rise together, ending the access on one edge
                    part_on_n_o      <= 1'b1;
                    write_strobe_n_o <= 1'b1;
                    output_drive_n_o <= 1'b1;
                    rdata_o          <= data_s2;
                    if (seq_mode && step != 3'h5) begin
                        step  <= step + 3'h1;
                        state <= nvsc_pkg::NVSC_SETUP;
                    end else if (seq_mode) begin
                        // Device busy; wait out save or restore
                        cnt <= (cur.op == nvsc_pkg::NVSC_OP_SAVE) ?
                               CNT_W'(SAVE_CYC) : CNT_W'(RESTORE_CYC);
                        state <= nvsc_pkg::NVSC_WAIT;
                    end else begin
                        done_o <= 1'b1;
                        state  <= nvsc_pkg::NVSC_IDLE;
                    end
                end
                nvsc_pkg::NVSC_WAIT: begin
                    cnt <= cnt - CNT_W'(1);
                    if (cnt == CNT_W'(1)) begin
                        step     <= 3'h0;
                        seq_mode <= 1'b0;
                        done_o   <= 1'b1;
                        state    <= nvsc_pkg::NVSC_IDLE;
                    end
                end
                default: state <= nvsc_pkg::NVSC_IDLE;
            endcase
        end
    end

    // Host drive overlapping a device read would clash on the data lines
    logic bus_drive_in_read;
    assign bus_drive_in_read = data_lines_oe_o && !output_drive_n_o;

    chk_no_contention: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !bus_drive_in_read)
        else $error("host drives data while device output on");

    chk_write_drive_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !write_strobe_n_o |-> output_drive_n_o)
        else $error("drive low during write");

    chk_addr_stable: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!part_on_n_o && $past(!part_on_n_o)) |-> $stable(addr_lines_o))
        else $error("address moved during access");

    chk_seq_reads_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (seq_mode && !part_on_n_o) |-> write_strobe_n_o)
        else $error("write inside a sequence");

    chk_seq_strobe_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (seq_mode && state != nvsc_pkg::NVSC_IDLE) |-> write_strobe_n_o)
        else $error("strobe low during sequence");

    chk_seq_first_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (seq_mode && step == 3'h0 && !part_on_n_o) |-> addr_lines_o == `NVSC_SEQ0)
        else $error("sequence not started at zero");

    chk_seq_last_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (seq_mode && step == 3'h5 && !part_on_n_o) |->
        addr_lines_o == ((cur.op == nvsc_pkg::NVSC_OP_SAVE) ? `NVSC_SEQ_SAVE : `NVSC_SEQ_RESTORE))
        else $error("wrong sixth address");

    chk_busy_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state == nvsc_pkg::NVSC_WAIT |-> (part_on_n_o && !req_ready_o))
        else $error("access during save or restore");

    // For a single access, done rises at the same edge that lifts select, so both are seen together
    chk_read_ends: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(part_on_n_o) && !seq_mode |-> done_o)
        else $error("single access did not complete");

    // Pins rest inactive while idle, so a power-up restore never sees a write
    chk_idle_ctl_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state == nvsc_pkg::NVSC_IDLE |-> (part_on_n_o && write_strobe_n_o && output_drive_n_o))
        else $error("control pin low while idle");

    // Select stays low for three cycles, one more than the counted access time, then lifts
    chk_select_width: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $fell(part_on_n_o) |-> !part_on_n_o [*3] ##1 part_on_n_o)
        else $error("select low for wrong number of cycles");

    // A write ends with select and strobe lifting on one edge
    chk_write_ends_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(write_strobe_n_o) |-> $rose(part_on_n_o))
        else $error("write strobe ended apart from select");
endmodule

// *** inc/nvsc_defines.svh ***
// Constants for the nonvolatile SRAM host controller
`ifndef NVSC_DEFINES_SVH
`define NVSC_DEFINES_SVH
`define NVSC_ADDR_W        13
`define NVSC_DATA_W        8
`define NVSC_SEQ0          13'h0000
`define NVSC_SEQ1          13'h1555
`define NVSC_SEQ2          13'h0AAA
`define NVSC_SEQ3          13'h1FFF
`define NVSC_SEQ4          13'h10F0
`define NVSC_SEQ_SAVE      13'h0F0F
`define NVSC_SEQ_RESTORE   13'h0F0E
`define NVSC_CLK_NS        100
`define NVSC_ACCESS_NS     200
`define NVSC_ACCESS_CYC    ((`NVSC_ACCESS_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_RESTORE_US    20
`define NVSC_RESTORE_CYC   ((`NVSC_RESTORE_US * 1000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_SAVE_MS       10
`define NVSC_SAVE_CYC      ((`NVSC_SAVE_MS * 1000000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`endif

// *** inc/nvsc_pkg.sv ***
// Types for the nonvolatile SRAM host controller
package nvsc_pkg;
    typedef enum logic [1:0] {
        NVSC_OP_READ    = 2'h0,
        NVSC_OP_WRITE   = 2'h1,
        NVSC_OP_SAVE    = 2'h2,
        NVSC_OP_RESTORE = 2'h3
    } nvsc_op_t;

    typedef struct packed {
        nvsc_op_t    op;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } nvsc_req_t;

    typedef enum logic [2:0] {
        NVSC_IDLE  = 3'b000,
        NVSC_SETUP = 3'b001,
        NVSC_PULSE = 3'b011,
        NVSC_HOLD  = 3'b010,
        NVSC_WAIT  = 3'b110
    } nvsc_state_t;
endpackage

// *** tb/nvsc_dev_model.sv ***
// Behavioural model of the shadowed SRAM device at the far side of the host
`timescale 1ns/1ps
`include "nvsc_defines.svh"
module nvsc_dev_model #(
    parameter int SAVE_NS    = 1500,
    parameter int RESTORE_NS = 800
) (
    input  wire logic [12:0] addr_i,
    input  wire logic        part_on_n_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        output_drive_n_i,
    input  wire logic        cap_low_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       data_o
);
    localparam logic [12:0] SEQ [5] = '{`NVSC_SEQ0, `NVSC_SEQ1, `NVSC_SEQ2, `NVSC_SEQ3,
                                        `NVSC_SEQ4};
    logic [7:0] mem [8192];
    logic [7:0] nv  [8192];
    logic       busy = 1'b0;
    logic       in_wr = 1'b0;
    logic       in_rd = 1'b0;
    logic [7:0] last = 8'h00;
    int         step = 0;
    wire        reading = !busy && !part_on_n_i && !output_drive_n_i && write_strobe_n_i;
    // Power-up restore loads an arbitrary nonvolatile pattern
    initial begin
        foreach (nv[i]) nv[i] = 8'hA5;
        mem = nv;
    end
    // Drive the addressed byte while reading, else an inverted stale value
    always @* begin
        if (reading) last = mem[addr_i];
    end
    assign data_o = reading ? mem[addr_i] : ~last;
    // Note which kind of access is under way
    always @* begin
        if (!busy && !part_on_n_i && !write_strobe_n_i) in_wr = 1'b1;
        if (!busy && !part_on_n_i && write_strobe_n_i) in_rd = 1'b1;
    end
    // Trailing edge: capture writes, step the sequence detector; the short
    // wait lets select and strobe that rise together count as one end
    always @(posedge write_strobe_n_i or posedge part_on_n_i) begin
        #1;
        if (busy) begin
            in_wr = 1'b0;
        end else if (in_wr) begin
            if (!cap_low_i) mem[addr_i] = data_i;
            in_wr = 1'b0;
            in_rd = 1'b0;
            step = 0;
        end else if (in_rd && part_on_n_i) begin
            in_rd = 1'b0;
            if (step < 5) begin
                step = (addr_i == SEQ[step]) ? step + 1 : ((addr_i == SEQ[0]) ? 1 : 0);
            end else begin
                step = 0;
                if (addr_i == `NVSC_SEQ_SAVE && !cap_low_i) begin
                    busy = 1'b1;
                    #SAVE_NS;
                    foreach (nv[i]) nv[i] = 8'hFF;
                    nv = mem;
                    busy = 1'b0;
                end else if (addr_i == `NVSC_SEQ_RESTORE) begin
                    busy = 1'b1;
                    foreach (mem[i]) mem[i] = 8'h00;
                    #RESTORE_NS;
                    mem = nv;
                    busy = 1'b0;
                end
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the host controller against the device model
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [1:0]  op;
        logic [12:0] a;
        logic [7:0]  wd;
        logic [7:0]  ex;
        logic        ck;
    } nvsc_row_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    nvsc_pkg::nvsc_req_t req_i = '0;
    logic req_valid_i = 1'b0;
    logic req_ready_o, done_o, data_lines_oe_o, part_on_n_o, write_strobe_n_o, output_drive_n_o;
    logic [7:0] rdata_o, data_lines_o, dev_data, data_lines_i;
    logic [7:0] ctl_pins;
    logic cap_low = 1'b0;
    logic [12:0] addr_lines_o;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    // Ordinary traffic: writes, reads, save, restore and an aborted sequence
    nvsc_row_t rows [24] = '{
        '{2'h1,13'h0000,8'h11,8'h00,1'b0}, '{2'h1,13'h1FFF,8'h5A,8'h00,1'b0},
        '{2'h0,13'h1FFF,8'h00,8'h5A,1'b1}, '{2'h0,13'h0000,8'h00,8'h11,1'b1},
        '{2'h2,13'h0000,8'h00,8'h00,1'b0}, '{2'h1,13'h0000,8'h22,8'h00,1'b0},
        '{2'h1,13'h0123,8'h44,8'h00,1'b0}, '{2'h0,13'h0000,8'h00,8'h22,1'b1},
        '{2'h3,13'h0000,8'h00,8'h00,1'b0}, '{2'h0,13'h0000,8'h00,8'h11,1'b1},
        '{2'h0,13'h0123,8'h00,8'hA5,1'b1}, '{2'h0,13'h1FFF,8'h00,8'h5A,1'b1},
        '{2'h1,13'h0000,8'h33,8'h00,1'b0}, '{2'h0,13'h0000,8'h00,8'h33,1'b1},
        '{2'h0,13'h1555,8'h00,8'hA5,1'b1}, '{2'h0,13'h0AAA,8'h00,8'hA5,1'b1},
        '{2'h0,13'h1FFF,8'h00,8'h5A,1'b1}, '{2'h0,13'h10F0,8'h00,8'hA5,1'b1},
        '{2'h1,13'h0123,8'h66,8'h00,1'b0}, '{2'h0,13'h0F0E,8'h00,8'hA5,1'b0},
        '{2'h0,13'h0000,8'h00,8'h33,1'b1}, '{2'h0,13'h0123,8'h00,8'h66,1'b1},
        '{2'h3,13'h0000,8'h00,8'h00,1'b0}, '{2'h0,13'h0000,8'h00,8'h11,1'b1}
    };
    // Shared data wire: host drives only when its enable is high
    assign data_lines_i = data_lines_oe_o ? data_lines_o : dev_data;
    // Control pins gathered for the reset checks
    assign ctl_pins = {5'h00, part_on_n_o, write_strobe_n_o, output_drive_n_o};
    nvsc_host #(.SAVE_CYC(20), .RESTORE_CYC(10)) i_nvsc_host (.clk_i(clk_i), .rstn_i(rstn_i),
        .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rdata_o(rdata_o),
        .done_o(done_o), .addr_lines_o(addr_lines_o), .data_lines_o(data_lines_o),
        .data_lines_oe_o(data_lines_oe_o), .data_lines_i(data_lines_i),
        .part_on_n_o(part_on_n_o), .write_strobe_n_o(write_strobe_n_o),
        .output_drive_n_o(output_drive_n_o));
    nvsc_dev_model i_nvsc_dev_model (.addr_i(addr_lines_o), .part_on_n_i(part_on_n_o),
        .write_strobe_n_i(write_strobe_n_o), .output_drive_n_i(output_drive_n_o),
        .cap_low_i(cap_low), .data_i(data_lines_i), .data_o(dev_data));
    // Clock and hang guard
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One request through the valid/ready handshake, then wait for done
    task automatic do_req(input nvsc_row_t r);
        int n;
        @(negedge clk_i);
        req_i = nvsc_pkg::nvsc_req_t'({r.op, r.a, r.wd});
        req_valid_i = 1'b1;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 500) begin
            @(negedge clk_i);
            n = n + 1;
        end
        // Ready stood high here, so the next rising edge takes the request
        @(negedge clk_i);
        req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 500) begin
            @(negedge clk_i);
            n = n + 1;
        end
        check("done", {7'h00, done_o}, 8'h01);
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        check("ctl_in_reset", ctl_pins, 8'h07);
        check("rdy_oe_in_reset", {6'h00, req_ready_o, data_lines_oe_o}, 8'h00);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        foreach (rows[i]) begin
            do_req(rows[i]);
            if (rows[i].ck) begin
                check("rdata", rdata_o, rows[i].ex);
            end
        end
        // Reset in mid-run returns controls to idle, then traffic resumes
        rstn_i = 1'b0;
        @(negedge clk_i);
        check("ctl_second_reset", ctl_pins, 8'h07);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        // Low storage voltage: the device drops the write and the old byte stays
        cap_low = 1'b1;
        do_req('{2'h1, 13'h0000, 8'h77, 8'h00, 1'b0});
        do_req('{2'h0, 13'h0000, 8'h00, 8'h11, 1'b1});
        check("rdata_low_cap", rdata_o, 8'h11);
        cap_low = 1'b0;
        conclude();
    end
endmodule
